// ==== shared/supply_mode_pkg.sv ====
/*
  Shared constants for the supply mode and wakeup sequencer: SFR
  offsets, field positions, reset values and the operating mode type.
  Assumes the 8-bit SFR bus of the on-chip processor core.
*/
package supply_mode_pkg;

  typedef enum logic [1:0]
  {
    normal_supply_mode,
    battery_run_mode,
    sleep_mode
  } mode_t;

  localparam logic [7:0] PULLUP0_OFS   = 8'hB2;
  localparam logic [7:0] PULLUP1_OFS   = 8'hB3;
  localparam logic [7:0] PULLUP2_OFS   = 8'hB4;
  localparam logic [7:0] POWER_CTL_OFS = 8'hC5;
  localparam logic [7:0] PERIPHERAL_CONFIG_OFS    = 8'hF4;
  localparam logic [7:0] SUPPLY_IRQ_OFS = 8'hF8;
  localparam logic [7:0] SCRATCH_OFS   = 8'hFB;

  localparam int SCRATCH_DEPTH = 4;
  localparam int SCRATCH_AW    = 2;

  localparam int PC_SHUTDOWN   = 4;
  localparam int PC_DCIN_WARN  = 5;
  localparam int PC_LCD_EN     = 3;
  localparam int PER_RX_FLAG   = 7;
  localparam int PER_SOURCE    = 6;
  localparam int IRQ_SOURCE    = 6;
  localparam int IRQ_RESTORE   = 4;
  localparam int IRQ_SWITCH    = 3;

  localparam logic [1:0] RX_WAKE_CFG  = 2'h3;
  localparam logic [1:0] PIN_B_WAKE   = 2'h3;
  localparam logic       PIN_A_WAKE   = 1'h1;

  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] PULLUP_RST   = 8'h00;
  localparam logic [7:0] POWER_RST    = 8'h00;

endpackage

// ==== rtl/scratch_mem.sv ====
/*
  Small byte memory for the scratch registers with registered read
  data. It has no reset, so its contents ride through every mode.
*/
`timescale 1ns/1ps
module scratch_mem
(
  // Clock and enable
  input  wire logic                                   clk_i,
  input  wire logic                                   ce_i,
  // Access port
  input  wire logic [supply_mode_pkg::SCRATCH_AW-1:0] addr_i,
  input  wire logic                                   we_i,
  input  wire logic [7:0]                             wdata_i,
  output logic      [7:0]                             rdata_o
);
  import supply_mode_pkg::*;

  logic [7:0] mem_q [SCRATCH_DEPTH];

  always_ff @(posedge clk_i)
  begin
    if (ce_i)
    begin
      if (we_i)
      begin
        mem_q[addr_i] <= wdata_i;
      end
      rdata_o <= mem_q[addr_i];
    end
  end

endmodule

// ==== rtl/supply_mode_seq.sv ====
/*
  Supply mode and wakeup sequencer: follows the switched rail source,
  enters sleep on software request while on battery, gathers wake sources and holds the
  power SFRs. Assumes all inputs synchronous to CLK_I and that the
  switchover circuitry qualifies its own events with their enables.
*/
`timescale 1ns/1ps
module supply_mode_seq
(
  // Clock, reset and enable
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  // SFR bus
  input  wire logic [7:0]  SFR_ADDR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  input  wire logic        SFR_WE_I,
  input  wire logic        SFR_RE_I,
  output logic      [7:0]  SFR_RDATA_O,
  output logic             SFR_RVALID_O,
  // Supply switchover circuitry
  input  wire logic        SWITCHOVER_EVT_I,
  input  wire logic        RESTORE_EVT_I,
  input  wire logic        SAG_I,
  input  wire logic        DCIN_LOW_I,
  // Wake sources
  input  wire logic        EXT_A_I,
  input  wire logic        EXT_B_I,
  input  wire logic        EXT_A_WAKE_CFG_I,
  input  wire logic [2:0]  EXT_B_WAKE_CFG_I,
  input  wire logic        EDGE_SEL_A_I,
  input  wire logic        EDGE_SEL_B_I,
  input  wire logic        RX_I,
  input  wire logic        RESET_PIN_N_I,
  input  wire logic        RTC_MIDNIGHT_I,
  input  wire logic        RTC_ALARM_I,
  input  wire logic        ALARM_EN_I,
  // Mode and power outputs
  output supply_mode_pkg::mode_t MODE_O,
  output logic             RAIL_ON_BATTERY_O,
  output logic             CORE_RUN_O,
  output logic             CORE_RESTART_O,
  output logic             ANALOG_EN_O,
  output logic             EARLY_WARN_O,
  output logic             LCD_EN_O,
  output logic             WAKE_O
);
  import supply_mode_pkg::*;

  mode_t      mode_q;
  mode_t      mode_d;
  logic [7:0] pull0_q;
  logic [7:0] pull1_q;
  logic [7:0] pull2_q;
  logic [7:0] pc_q;
  logic [7:0] pc_d;
  logic [1:0] rx_cfg_q;
  logic       rx_flag_q;
  logic       rx_flag_d;
  logic       restore_flag_q;
  logic       restore_flag_d;
  logic       switch_flag_q;
  logic       switch_flag_d;
  logic       ext_a_prev_q;
  logic       ext_b_prev_q;
  logic       rx_prev_q;
  logic [7:0] local_rd_q;
  logic       scr_sel_q;
  logic       rd_pend_q;
  logic [7:0] scr_rdata;

  wire        in_normal   = (mode_q == normal_supply_mode);
  wire        in_battery  = (mode_q == battery_run_mode);
  wire        in_sleep    = (mode_q == sleep_mode);
  wire        source_main = ~RAIL_ON_BATTERY_O;

  wire        sel_pull0   = (SFR_ADDR_I == PULLUP0_OFS);
  wire        sel_pull1   = (SFR_ADDR_I == PULLUP1_OFS);
  wire        sel_pull2   = (SFR_ADDR_I == PULLUP2_OFS);
  wire        sel_pc      = (SFR_ADDR_I == POWER_CTL_OFS);
  wire        sel_per     = (SFR_ADDR_I == PERIPHERAL_CONFIG_OFS);
  wire        sel_irq     = (SFR_ADDR_I == SUPPLY_IRQ_OFS);
  wire [7:0]  scr_ofs     = SFR_ADDR_I - SCRATCH_OFS;
  wire        sel_scr     = (SFR_ADDR_I >= SCRATCH_OFS) &&
                            (scr_ofs < 8'(SCRATCH_DEPTH));
  wire        we_pc       = SFR_WE_I & sel_pc;
  wire        we_per      = SFR_WE_I & sel_per;
  wire        we_irq      = SFR_WE_I & sel_irq;

  // Edge history resets to the idle high level; select 1 is falling.
  wire        fall_a      = ext_a_prev_q & ~EXT_A_I;
  wire        rise_a      = ~ext_a_prev_q & EXT_A_I;
  wire        fall_b      = ext_b_prev_q & ~EXT_B_I;
  wire        rise_b      = ~ext_b_prev_q & EXT_B_I;
  wire        rx_edge     = rx_prev_q ^ RX_I;

  wire        wake_a      = (EXT_A_WAKE_CFG_I == PIN_A_WAKE) &
                            (EDGE_SEL_A_I ? fall_a : rise_a);
  wire        wake_b      = (EXT_B_WAKE_CFG_I[2:1] == PIN_B_WAKE) &
                            (EDGE_SEL_B_I ? fall_b : rise_b);
  wire        wake_rx     = (rx_cfg_q == RX_WAKE_CFG) & rx_edge;
  wire        wake_rtc    = RTC_MIDNIGHT_I | (RTC_ALARM_I & ALARM_EN_I);
  wire        wake_req    = in_sleep & (wake_a | wake_b | wake_rx |
                            wake_rtc | ~RESET_PIN_N_I);

  wire        warn_d      = SAG_I | (DCIN_LOW_I & pc_q[PC_DCIN_WARN]);
  wire [7:0]  per_rd      = {rx_flag_q, source_main, 4'h0, rx_cfg_q};
  wire [7:0]  irq_rd      = {1'b0, source_main, 1'b0, restore_flag_q,
                            switch_flag_q, 3'h0};
  wire [7:0]  local_rd    = sel_pull0 ? pull0_q :
                            sel_pull1 ? pull1_q :
                            sel_pull2 ? pull2_q :
                            sel_pc    ? pc_q :
                            sel_per   ? per_rd :
                            sel_irq   ? irq_rd : BYTE_ZERO;

  // Mode sequencing; restore outranks every wake source.
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      normal_supply_mode:
      begin
        if (SWITCHOVER_EVT_I)
        begin
          mode_d = battery_run_mode;
        end
      end
      battery_run_mode:
      begin
        if (RESTORE_EVT_I)
        begin
          mode_d = normal_supply_mode;
        end
        else if (pc_q[PC_SHUTDOWN])
        begin
          mode_d = sleep_mode;
        end
      end
      sleep_mode:
      begin
        if (RESTORE_EVT_I)
        begin
          mode_d = normal_supply_mode;
        end
        else if (wake_req)
        begin
          mode_d = battery_run_mode;
        end
      end
      default:
      begin
        mode_d = normal_supply_mode;
      end
    endcase
  end

  always_comb
  begin
    pc_d = pc_q;
    if (we_pc)
    begin
      pc_d = SFR_WDATA_I;
      pc_d[PC_SHUTDOWN] = SFR_WDATA_I[PC_SHUTDOWN] & ~in_normal;
    end
    if ((mode_d != sleep_mode) && (mode_d != mode_q))
    begin
      pc_d[PC_SHUTDOWN] = 1'b0;
    end
  end

  assign rx_flag_d = wake_rx |
                     (rx_flag_q & ~(we_per & ~SFR_WDATA_I[PER_RX_FLAG]));
  assign restore_flag_d = (RESTORE_EVT_I & ~in_normal) |
    (restore_flag_q & ~(we_irq & ~SFR_WDATA_I[IRQ_RESTORE]));
  assign switch_flag_d = (SWITCHOVER_EVT_I & in_normal) |
    (switch_flag_q & ~(we_irq & ~SFR_WDATA_I[IRQ_SWITCH]));

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      mode_q            <= normal_supply_mode;
      pull0_q           <= PULLUP_RST;
      pull1_q           <= PULLUP_RST;
      pull2_q           <= PULLUP_RST;
      pc_q              <= POWER_RST;
      rx_cfg_q          <= 2'h0;
      rx_flag_q         <= 1'b0;
      restore_flag_q    <= 1'b0;
      switch_flag_q     <= 1'b0;
      ext_a_prev_q      <= 1'b1;
      ext_b_prev_q      <= 1'b1;
      rx_prev_q         <= 1'b1;
    end
    else if (CE_I)
    begin
      mode_q            <= mode_d;
      pc_q              <= pc_d;
      rx_flag_q         <= rx_flag_d;
      restore_flag_q    <= restore_flag_d;
      switch_flag_q     <= switch_flag_d;
      ext_a_prev_q      <= EXT_A_I;
      ext_b_prev_q      <= EXT_B_I;
      rx_prev_q         <= RX_I;
      if (SFR_WE_I && sel_pull0)
      begin
        pull0_q <= SFR_WDATA_I;
      end
      if (SFR_WE_I && sel_pull1)
      begin
        pull1_q <= SFR_WDATA_I;
      end
      if (SFR_WE_I && sel_pull2)
      begin
        pull2_q <= SFR_WDATA_I;
      end
      if (we_per)
      begin
        rx_cfg_q <= SFR_WDATA_I[1:0];
      end
    end
  end

  // Rail, run, restart and analog outputs follow the next mode so they change with MODE_O.
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      MODE_O            <= normal_supply_mode;
      RAIL_ON_BATTERY_O <= 1'b0;
      CORE_RUN_O        <= 1'b1;
      CORE_RESTART_O    <= 1'b0;
      ANALOG_EN_O       <= 1'b1;
      EARLY_WARN_O      <= 1'b0;
      LCD_EN_O          <= 1'b0;
      WAKE_O            <= 1'b0;
    end
    else if (CE_I)
    begin
      MODE_O            <= mode_d;
      RAIL_ON_BATTERY_O <= (mode_d != normal_supply_mode);
      CORE_RUN_O        <= (mode_d != sleep_mode);
      CORE_RESTART_O    <= in_sleep & (mode_d != sleep_mode);
      ANALOG_EN_O       <= (mode_d == normal_supply_mode);
      EARLY_WARN_O      <= warn_d;
      LCD_EN_O          <= pc_d[PC_LCD_EN];
      WAKE_O            <= wake_req;
    end
  end

  // Two stage read so scratch and SFR data share one latency.
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      local_rd_q   <= BYTE_ZERO;
      scr_sel_q    <= 1'b0;
      rd_pend_q    <= 1'b0;
      SFR_RDATA_O  <= BYTE_ZERO;
      SFR_RVALID_O <= 1'b0;
    end
    else if (CE_I)
    begin
      local_rd_q   <= local_rd;
      scr_sel_q    <= sel_scr;
      rd_pend_q    <= SFR_RE_I;
      SFR_RDATA_O  <= scr_sel_q ? scr_rdata : local_rd_q;
      SFR_RVALID_O <= rd_pend_q;
    end
  end

  scratch_mem u_scratch
  (
    .clk_i   (CLK_I),
    .ce_i    (CE_I),
    .addr_i  (scr_ofs[SCRATCH_AW-1:0]),
    .we_i    (SFR_WE_I & sel_scr),
    .wdata_i (SFR_WDATA_I),
    .rdata_o (scr_rdata)
  );

  a_shutdown_to_sleep: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_battery && pc_q[PC_SHUTDOWN] && !RESTORE_EVT_I
    |=> MODE_O == sleep_mode && !CORE_RUN_O)
    else $error("Shutdown on battery did not enter sleep.");

  a_normal_no_sleep: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_normal && we_pc |=> !pc_q[PC_SHUTDOWN])
    else $error("Shutdown bit accepted on main supply.");

  a_wake_restart: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_sleep && wake_req && !RESTORE_EVT_I
    |=> MODE_O == battery_run_mode && CORE_RESTART_O && CORE_RUN_O)
    else $error("Wake did not restart the core on battery.");

  a_pin_reset_wake: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_sleep && !RESET_PIN_N_I && !RESTORE_EVT_I
    |=> MODE_O == battery_run_mode)
    else $error("Reset pin did not wake from sleep.");

  a_sleep_restore: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_sleep && RESTORE_EVT_I
    |=> MODE_O == normal_supply_mode && CORE_RESTART_O && ANALOG_EN_O)
    else $error("Restore in sleep did not fully restart.");

  a_battery_restore: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_battery && RESTORE_EVT_I
    |=> MODE_O == normal_supply_mode && !CORE_RESTART_O && ANALOG_EN_O)
    else $error("Restore on battery misbehaved.");

  a_switchover_mode: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_normal && SWITCHOVER_EVT_I
    |=> RAIL_ON_BATTERY_O && !ANALOG_EN_O && in_battery)
    else $error("Switchover did not move to battery run.");

  a_rx_flag_set: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && wake_rx |=> rx_flag_q)
    else $error("Receive edge flag not set.");

  a_source_mirror: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    per_rd[PER_SOURCE] == irq_rd[IRQ_SOURCE] &&
    per_rd[PER_SOURCE] == (MODE_O == normal_supply_mode))
    else $error("Supply source bits disagree with mode.");

  a_wake_in_sleep: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && !in_sleep |=> !WAKE_O)
    else $error("Wake raised outside sleep.");

  a_early_warn: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && SAG_I |=> EARLY_WARN_O)
    else $error("Voltage dip gave no warning.");

  a_midnight_wake: assert property (@(posedge CLK_I)
    disable iff (!RST_N_I)
    CE_I && in_sleep && RTC_MIDNIGHT_I |=> WAKE_O)
    else $error("Midnight did not wake.");

endmodule

// ==== tb/supply_partner.sv ====
/*
  Behavioural model of the supply switchover circuitry.
  Assumes the bench requests loss or return of main supply by pulses.
*/
`timescale 1ns/1ps
module supply_partner
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Bench requests
  input  wire logic lose_i,
  input  wire logic regain_i,
  // Towards the sequencer
  output logic      sag_o,
  output logic      dcin_low_o,
  output logic      switch_o,
  output logic      restore_o
);
  logic [1:0] cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_q <= 2'h0;
    else if (lose_i)
      cnt_q <= 2'h3;
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      restore_o <= 1'b0;
    else
      restore_o <= regain_i;
  end

  // The dip lasts one cycle so the sense term is seen on its own.
  assign sag_o      = (cnt_q == 2'h3);
  assign dcin_low_o = (cnt_q != 2'h0);
  assign switch_o   = (cnt_q == 2'h1);
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the supply mode sequencer.
  Assumes the supply partner model and the shared package.
*/
`timescale 1ns/1ps
module testbench;
  import supply_mode_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic       lose = 1'b0;
  logic       regain = 1'b0;
  logic       ext_a = 1'b1;
  logic       ext_b = 1'b0;
  logic       rx = 1'b1;
  logic       rpin_n = 1'b1;
  logic       mid = 1'b0;
  logic       alarm = 1'b0;
  logic       alarm_en = 1'b0;
  logic [2:0] cfg_b = 3'h7;
  logic       ce = 1'b1;
  logic       cfg_a = 1'b1;
  logic       sel_a = 1'b1;
  logic       sel_b = 1'b0;
  wire  [7:0] rdata;
  wire        rvalid, voltage_dip_detect, dcin, swo, rsto;
  wire        on_bat, run, restart, analog, warn, lcd, wake;
  mode_t      mode;
  int         n_fail = 0;
  int         comparisons = 0;
  int         n_restart = 0;
  int         cycles = 0;

  supply_partner partner (.clk_i(clk), .rst_n_i(rst_n), .lose_i(lose),
    .regain_i(regain), .sag_o(voltage_dip_detect), .dcin_low_o(dcin), .switch_o(swo),
    .restore_o(rsto));

  supply_mode_seq dut (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
    .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata), .SFR_WE_I(we), .SFR_RE_I(re),
    .SFR_RDATA_O(rdata), .SFR_RVALID_O(rvalid), .SWITCHOVER_EVT_I(swo),
    .RESTORE_EVT_I(rsto), .SAG_I(voltage_dip_detect), .DCIN_LOW_I(dcin), .EXT_A_I(ext_a),
    .EXT_B_I(ext_b), .EXT_A_WAKE_CFG_I(cfg_a), .EXT_B_WAKE_CFG_I(cfg_b),
    .EDGE_SEL_A_I(sel_a), .EDGE_SEL_B_I(sel_b), .RX_I(rx),
    .RESET_PIN_N_I(rpin_n), .RTC_MIDNIGHT_I(mid), .RTC_ALARM_I(alarm),
    .ALARM_EN_I(alarm_en), .MODE_O(mode), .RAIL_ON_BATTERY_O(on_bat),
    .CORE_RUN_O(run), .CORE_RESTART_O(restart), .ANALOG_EN_O(analog),
    .EARLY_WARN_O(warn), .LCD_EN_O(lcd), .WAKE_O(wake));

  always #2.5 clk = ~clk;

  // Restart pulses last one cycle; counted mid cycle where they settle.
  always @(negedge clk)
  begin
    cycles++;
    if (restart === 1'b1)
      n_restart++;
    if (cycles == 5000)
    begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    int i;
    @(negedge clk);
    addr = a;
    re = 1'b1;
    @(negedge clk);
    re = 1'b0;
    for (i = 0; i < 4 && rvalid !== 1'b1; i++)
      @(negedge clk);
    chk({what, " valid"}, 8'h01, {7'h0, rvalid});
    chk(what, exp, rdata);
  endtask

  task automatic stat(input logic [1:0] m, input logic bat, input logic an);
    chk("mode", {6'h0, m}, {6'h0, mode});
    chk("rail and analog", {6'h0, bat, an}, {6'h0, on_bat, analog});
  endtask

  // The display bit written with the sleep request must hold in sleep.
  task automatic sleep_now(input logic [7:0] d);
    wr(POWER_CTL_OFS, d);
    step(2);
    chk("sleep run lcd", {7'h0, d[PC_LCD_EN]}, {6'h0, run, lcd});
  endtask

  task automatic quiet(input string what);
    step(2);
    chk(what, {6'h0, sleep_mode}, {6'h0, mode});
  endtask

  task automatic poke(input int k);
    case (k)
      0: ext_a = 1'b0;
      1: ext_b = 1'b1;
      2: rx = 1'b0;
      3: mid = 1'b1;
      4: alarm_en = 1'b1;
      default: rpin_n = 1'b0;
    endcase
    alarm = (k == 4);
    step(1);
    chk("wake pulse", 8'h01, {7'h0, wake});
    step(1);
    {ext_a, ext_b, rx, rpin_n} = 4'b1011;
    {mid, alarm, alarm_en} = 3'b000;
    step(2);
  endtask

  task automatic lose_main(input logic en);
    lose = 1'b1;
    step(1);
    lose = 1'b0;
    step(1);
    chk("early warning", 8'h01, {7'h0, warn});
    step(1);
    chk("dc sense warning", {7'h0, en}, {7'h0, warn});
    step(3);
    stat(2'h1, 1'b1, 1'b0);
  endtask

  initial
  begin
    int i;
    step(12);
    rst_n = 1'b1;
    stat(2'h0, 1'b0, 1'b1);
    rd(SUPPLY_IRQ_OFS, 8'h40, "irq flags");
    rd(PERIPHERAL_CONFIG_OFS, 8'h40, "peripheral_config");
    wr(POWER_CTL_OFS, 8'h10);
    rd(POWER_CTL_OFS, 8'h00, "shutdown in normal");
    wr(8'hA0, 8'h55);
    rd(8'hA0, 8'h00, "unmapped");
    for (i = 0; i < 3; i++)
    begin
      wr(PULLUP0_OFS + i[7:0], 8'h5A ^ i[7:0]);
      rd(PULLUP0_OFS + i[7:0], 8'h5A ^ i[7:0], "pull-up");
    end
    $display("Test registers done");
    step(1);
    lose_main(1'b0);
    rd(SUPPLY_IRQ_OFS, 8'h08, "switch flag");
    rd(PERIPHERAL_CONFIG_OFS, 8'h00, "peripheral_config on battery");
    wr(SUPPLY_IRQ_OFS, 8'h00);
    rd(SUPPLY_IRQ_OFS, 8'h00, "flag cleared");
    for (i = 0; i < 4; i++)
      wr(SCRATCH_OFS + i[7:0], 8'hA0 + i[7:0]);
    wr(PERIPHERAL_CONFIG_OFS, 8'h03);
    $display("Test switchover done");
    for (i = 0; i < 6; i++)
    begin
      sleep_now(8'h18);
      poke(i);
      stat(2'h1, 1'b1, 1'b0);
      chk("restarts", i[7:0] + 8'h1, n_restart[7:0]);
    end
    rd(PERIPHERAL_CONFIG_OFS, 8'h83, "rx flag");
    $display("Test wake sources done");
    sleep_now(8'h10);
    alarm = 1'b1;
    step(2);
    alarm = 1'b0;
    step(2);
    chk("masked alarm", {6'h0, sleep_mode}, {6'h0, mode});
    sel_a = 1'b0;
    ext_a = 1'b0;
    quiet("pin A wrong edge");
    sel_a = 1'b1;
    ext_a = 1'b1;
    cfg_a = 1'b0;
    step(2);
    ext_a = 1'b0;
    quiet("pin A masked");
    ext_a = 1'b1;
    cfg_a = 1'b1;
    sel_b = 1'b1;
    step(2);
    ext_b = 1'b1;
    quiet("pin B wrong edge");
    ext_b = 1'b0;
    sel_b = 1'b0;
    cfg_b = 3'h4;
    step(2);
    ext_b = 1'b1;
    quiet("pin B masked");
    ext_b = 1'b0;
    cfg_b = 3'h6;
    ce = 1'b0;
    rpin_n = 1'b0;
    quiet("frozen by enable");
    rpin_n = 1'b1;
    ce = 1'b1;
    step(2);
    $display("Test masked wakes done");
    regain = 1'b1;
    step(1);
    regain = 1'b0;
    step(3);
    stat(2'h0, 1'b0, 1'b1);
    chk("restart on restore", 8'h07, n_restart[7:0]);
    rd(SUPPLY_IRQ_OFS, 8'h50, "restore flag");
    for (i = 0; i < 4; i++)
      rd(SCRATCH_OFS + i[7:0], 8'hA0 + i[7:0], "scratch");
    $display("Test restore from sleep done");
    wr(POWER_CTL_OFS, 8'h20);
    lose_main(1'b1);
    regain = 1'b1;
    step(1);
    regain = 1'b0;
    step(3);
    stat(2'h0, 1'b0, 1'b1);
    chk("no restart", 8'h07, n_restart[7:0]);
    $display("Test restore on battery done");
    close_out();
  end
endmodule
